// *** core/lcd_rb_pkg.sv ***
/*
 * constants for the two-wire readback path of the character display
 * controller: slave address, control byte fields, instruction codes.
 * assumes a single clock domain, used by the core module and the test bench.
 */
package lcd_rb_pkg;
    localparam logic [5:0] SLAVE_ADDR_HI  = 6'h1D; // upper six address bits
    localparam int         RW_BIT         = 0;     // read/write bit of address byte
    localparam int         CONT_BIT       = 7;     // continuation_flag position
    localparam int         SELECT_BIT     = 6;     // register_select position
    localparam int         MSB            = 7;     // most_significant_bit
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam int         SET_ADDR_BIT   = 7;     // set-address instruction flag
    localparam logic [6:0] RET_HOME_CODE  = 7'h01; // bits 7..1 of return-to-origin
    localparam logic [4:0] SHIFT_CODE     = 5'h03; // bits 7..3 of shift instruction
    localparam int         SHIFT_DISP_BIT = 3;     // 1: shift display, 0: cursor
    localparam int         SHIFT_DIR_BIT  = 2;     // 1: right
    localparam logic [6:0] ORIGIN_ADDR    = 7'h00;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_CTRL, ST_CACK, ST_DATA, ST_DACK, ST_TX, ST_MACK
    } link_state_e;
endpackage

// *** core/lcd_readback.sv ***
/*
 * two-wire slave path of the display controller: receives control bytes,
 * instructions and text data, executes return-to-origin, set-address and
 * shift, and returns display text memory byte by byte on read.
 * assumes scl/sda already synchronous to clk_sys_in; the wire level is
 * resolved outside from sda_out and sda_oe_out (open drain).
 */
// How it works
// - return-to-origin loads address counter with zero
// - return-to-origin undoes shift, memory left intact
// - return-to-origin leaves data register untouched
// - read address ack copies data register out
// - data register valid only after set/read
// - read byte shifted out msb first, 8 clocks
// - master ack advances counter, loads next byte
// - master nack causes no internal action
// - register select picks instruction or memory data
// - instruction executes on its ack clock pulse
// - own address acknowledged by pulling line low
`timescale 1ns/100ps
module lcd_readback #(
    parameter int MEM_DEPTH = 80
) (
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       address_select_pin_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic [6:0]      address_counter_out,
    output logic [6:0]      display_shift_out,
    output logic [7:0]      data_register_out,
    output logic            data_valid_out
);
    lcd_rb_pkg::link_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] byte_q;
    logic [7:0] tx_q;
    logic [7:0] dreg_q;
    logic [6:0] ac_q;
    logic [6:0] shift_q;
    logic       rw_q, reg_sel_q, cont_q, acked_q, valid_q, oe_q;
    logic       scl_q, sda_q, scl_prev_q, sda_prev_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic       rise_w, fall_w, start_w, stop_w, match_w, exec_w, home_w;

    // counter steps and wraps at the end of text memory
    function automatic logic [6:0] next_addr(input logic [6:0] a);
        next_addr = (32'(a) >= MEM_DEPTH - 1) ? lcd_rb_pkg::ORIGIN_ADDR : a + 7'h01;
    endfunction

    // out-of-range addresses read zero instead of indexing past the array
    function automatic logic [7:0] mem_rd(input logic [6:0] a);
        mem_rd = (32'(a) < MEM_DEPTH) ? mem_q[a] : 8'h00;
    endfunction

    // one stage of history for edge and start/stop detection
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_q      <= scl_in;
            sda_q      <= sda_in;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    assign rise_w  = scl_q & ~scl_prev_q;
    assign fall_w  = ~scl_q & scl_prev_q;
    assign start_w = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign stop_w  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
    assign match_w = (byte_q[7:1] == {lcd_rb_pkg::SLAVE_ADDR_HI, address_select_pin_in});
    // instruction byte at the rising edge of its own ack pulse
    assign exec_w  = rise_w && state_q == lcd_rb_pkg::ST_DACK && !reg_sel_q;
    assign home_w  = exec_w && byte_q[7:1] == lcd_rb_pkg::RET_HOME_CODE;

    // byte framing and sequence control
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state_q   <= lcd_rb_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            byte_q    <= 8'h00;
            rw_q      <= 1'b0;
            reg_sel_q <= 1'b0;
            cont_q    <= 1'b0;
            acked_q   <= 1'b0;
        end else if (start_w) begin
            state_q   <= lcd_rb_pkg::ST_ADDR; // repeated start needs no stop
            bit_cnt_q <= 4'h0;
        end else if (stop_w) begin
            state_q <= lcd_rb_pkg::ST_IDLE;
        end else begin
            case (state_q)
                lcd_rb_pkg::ST_ADDR, lcd_rb_pkg::ST_CTRL, lcd_rb_pkg::ST_DATA: begin
                    if (rise_w) begin
                        byte_q    <= {byte_q[6:0], sda_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (fall_w && bit_cnt_q == lcd_rb_pkg::BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == lcd_rb_pkg::ST_ADDR) begin
                            state_q <= match_w ? lcd_rb_pkg::ST_AACK : lcd_rb_pkg::ST_IDLE;
                            rw_q    <= byte_q[lcd_rb_pkg::RW_BIT];
                        end else if (state_q == lcd_rb_pkg::ST_CTRL) begin
                            state_q <= lcd_rb_pkg::ST_CACK;
                        end else begin
                            state_q <= lcd_rb_pkg::ST_DACK;
                        end
                    end
                end
                lcd_rb_pkg::ST_AACK: begin
                    if (fall_w) begin
                        state_q <= rw_q ? lcd_rb_pkg::ST_TX : lcd_rb_pkg::ST_CTRL;
                    end
                end
                lcd_rb_pkg::ST_CACK: begin
                    if (rise_w) begin
                        reg_sel_q <= byte_q[lcd_rb_pkg::SELECT_BIT]; // data or instr
                        cont_q    <= byte_q[lcd_rb_pkg::CONT_BIT];
                    end
                    if (fall_w) begin
                        state_q <= lcd_rb_pkg::ST_DATA;
                    end
                end
                lcd_rb_pkg::ST_DACK: begin
                    // a set continuation flag means one byte, then a new control byte
                    if (fall_w) begin
                        state_q <= cont_q ? lcd_rb_pkg::ST_CTRL : lcd_rb_pkg::ST_DATA;
                    end
                end
                lcd_rb_pkg::ST_TX: begin
                    if (rise_w) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (fall_w && bit_cnt_q == lcd_rb_pkg::BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        state_q   <= lcd_rb_pkg::ST_MACK; // master owns the line
                    end
                end
                lcd_rb_pkg::ST_MACK: begin
                    if (rise_w) begin
                        acked_q <= ~sda_q;
                    end
                    if (fall_w) begin
                        state_q <= acked_q ? lcd_rb_pkg::ST_TX : lcd_rb_pkg::ST_IDLE;
                    end
                end
                default: state_q <= lcd_rb_pkg::ST_IDLE;
            endcase
        end
    end

    // address counter, display shift and data register
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ac_q    <= lcd_rb_pkg::ORIGIN_ADDR;
            shift_q <= 7'h00;
            dreg_q  <= 8'h00;
            valid_q <= 1'b0;
        end else if (home_w) begin
            ac_q    <= lcd_rb_pkg::ORIGIN_ADDR;
            shift_q <= 7'h00;
            valid_q <= 1'b0;                    // dreg_q kept as it was
        end else if (exec_w && byte_q[lcd_rb_pkg::SET_ADDR_BIT]) begin
            ac_q    <= byte_q[6:0];
            dreg_q  <= mem_rd(byte_q[6:0]);
            valid_q <= 1'b1;
        end else if (exec_w && byte_q[7:3] == lcd_rb_pkg::SHIFT_CODE) begin
            if (byte_q[lcd_rb_pkg::SHIFT_DISP_BIT]) begin
                shift_q <= byte_q[lcd_rb_pkg::SHIFT_DIR_BIT] ? shift_q + 7'h01
                                                              : shift_q - 7'h01;
            end
            valid_q <= 1'b0;
        end else if (exec_w) begin
            valid_q <= 1'b0; // other instructions leave the register stale
        end else if (rise_w && state_q == lcd_rb_pkg::ST_DACK) begin
            ac_q    <= next_addr(ac_q); // text write; data register not refreshed
            valid_q <= 1'b0;
        end else if (rise_w && state_q == lcd_rb_pkg::ST_MACK && !sda_q) begin
            ac_q    <= next_addr(ac_q);
            dreg_q  <= mem_rd(next_addr(ac_q));
            valid_q <= 1'b1;
        end
        // a withheld acknowledge falls through with nothing changed
    end

    // display text memory, written by data bytes with register select set
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (rise_w && state_q == lcd_rb_pkg::ST_DACK && reg_sel_q
                     && 32'(ac_q) < MEM_DEPTH) begin
            mem_q[ac_q] <= byte_q;
        end
    end

    // interface shift register for read bytes
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            tx_q <= 8'h00;
        end else if (rise_w && state_q == lcd_rb_pkg::ST_AACK && rw_q) begin
            tx_q <= dreg_q; // possibly stale, see data_valid_out
        end else if (rise_w && state_q == lcd_rb_pkg::ST_MACK && !sda_q) begin
            tx_q <= mem_rd(next_addr(ac_q));
        end else if (fall_w && state_q == lcd_rb_pkg::ST_TX) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // open-drain data line; changes while scl is low, and is released at start and stop
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || start_w || stop_w) begin
            oe_q <= 1'b0;
        end else if (fall_w) begin
            case (state_q)
                lcd_rb_pkg::ST_ADDR: begin
                    oe_q <= bit_cnt_q == lcd_rb_pkg::BITS_PER_BYTE && match_w;
                end
                lcd_rb_pkg::ST_CTRL, lcd_rb_pkg::ST_DATA: begin
                    oe_q <= bit_cnt_q == lcd_rb_pkg::BITS_PER_BYTE;
                end
                lcd_rb_pkg::ST_AACK: oe_q <= rw_q && !tx_q[lcd_rb_pkg::MSB];
                lcd_rb_pkg::ST_TX: begin
                    oe_q <= bit_cnt_q != lcd_rb_pkg::BITS_PER_BYTE && !tx_q[lcd_rb_pkg::MSB - 1];
                end
                lcd_rb_pkg::ST_MACK: oe_q <= acked_q && !tx_q[lcd_rb_pkg::MSB];
                default: oe_q <= 1'b0;
            endcase
        end
    end

    assign sda_out             = 1'b0; // open drain: only ever pulls low
    assign sda_oe_out          = oe_q;
    assign address_counter_out = ac_q;
    assign display_shift_out   = shift_q;
    assign data_register_out   = dreg_q;
    assign data_valid_out      = valid_q;

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    a_home_counter: assert property (home_w |=> ac_q == 7'h00)
        else $error("return-to-origin did not clear the address counter");
    a_home_shift: assert property (home_w |=> shift_q == 7'h00)
        else $error("return-to-origin did not undo the display shift");
    a_home_dreg: assert property (home_w |=> $stable(dreg_q))
        else $error("return-to-origin changed the data register");
    a_read_load: assert property (
        rise_w && state_q == lcd_rb_pkg::ST_AACK && rw_q |=> tx_q == $past(dreg_q))
        else $error("read address ack did not load the data register");
    a_set_valid: assert property (
        exec_w && byte_q[7] |=> valid_q && dreg_q == mem_rd(ac_q))
        else $error("set address did not make the data register valid");
    a_first_bit: assert property (
        fall_w && state_q == lcd_rb_pkg::ST_AACK && rw_q |=> oe_q == !$past(tx_q[7]))
        else $error("first read bit is not the msb");
    a_ack_advance: assert property (
        rise_w && state_q == lcd_rb_pkg::ST_MACK && !sda_q
        |=> ac_q == next_addr($past(ac_q)) && tx_q == dreg_q)
        else $error("master ack did not advance and reload");
    a_nack_quiet: assert property (
        rise_w && state_q == lcd_rb_pkg::ST_MACK && sda_q
        |=> $stable(ac_q) && $stable(dreg_q) && $stable(tx_q))
        else $error("master nack caused internal action");
    a_sel_latch: assert property (
        rise_w && state_q == lcd_rb_pkg::ST_CACK
        |=> reg_sel_q == $past(byte_q[lcd_rb_pkg::SELECT_BIT]))
        else $error("register select not taken from control byte");
    a_addr_ack: assert property (
        fall_w && state_q == lcd_rb_pkg::ST_ADDR && bit_cnt_q == 4'h8 && match_w
        |=> oe_q ##1 oe_q)
        else $error("own address not acknowledged");
    a_restart: assert property (start_w |=> state_q == lcd_rb_pkg::ST_ADDR)
        else $error("start not accepted");

    c_home: cover property (home_w);
    c_read_ack: cover property (rise_w && state_q == lcd_rb_pkg::ST_MACK && !sda_q);
    c_read_nack: cover property (rise_w && state_q == lcd_rb_pkg::ST_MACK && sda_q);
    c_restart: cover property (start_w && state_q != lcd_rb_pkg::ST_IDLE);
endmodule

// *** testbench/host_master.sv ***
/*
 * behavioural two-wire bus master standing in for the host controller.
 * assumes the bench resolves the open-drain data wire with a pull-up
 * and feeds the level back on sda_in; scl rests high outside frames.
 */
`timescale 1ns/100ps
module host_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // idle bus: both lines released
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    // every change lands just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // data moves mid-low so the slave sees it stable around both scl edges
    task automatic clk_bit(input logic b, output logic seen);
        sda_low_out = ~b;
        tick(5);
        scl_out = 1'b1;
        tick(8);
        seen    = sda_in;
        scl_out = 1'b0;
        tick(5);
    endtask

    // works as a plain or a repeated start, whichever phase scl is in
    task automatic bus_start;
        if (!scl_out) begin
            sda_low_out = 1'b0;
            tick(5);
            scl_out = 1'b1;
            tick(8);
        end
        sda_low_out = 1'b1;
        tick(8);
        scl_out = 1'b0;
        tick(5);
    endtask

    task automatic bus_stop;
        sda_low_out = 1'b1;
        tick(5);
        scl_out = 1'b1;
        tick(8);
        sda_low_out = 1'b0;
        tick(8);
    endtask

    // line released in the ninth slot so the device can answer
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask

    // master acknowledge only when more bytes are wanted
    task automatic read_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(~give_ack, s);
    endtask
endmodule

// *** testbench/test_lcd_i2c_readback_path.sv ***
/*
 * self-checking bench for the display readback path: writes text,
 * moves the counter, returns to origin and reads memory back.
 * assumes host_master drives the bus and a pull-up on the data wire.
 */
`timescale 1ns/100ps
module test_lcd_i2c_readback_path;
    localparam logic [47:0] TEXT = 48'h5349474E414C; // six text bytes
    logic       clk_sys_in;
    logic       reset_n_in;
    logic       address_select_pin_in;
    wire        scl;
    wire        sda_low;
    wire        sda_line;
    logic       sda_out;
    logic       sda_oe_out;
    logic [6:0] address_counter_out;
    logic [6:0] display_shift_out;
    logic [7:0] data_register_out;
    logic       data_valid_out;
    logic       ack;
    logic [7:0] rd;
    int         err_count = 0;
    int         samples_checked = 0;

    // wired-and of both parties; released line floats up
    assign sda_line = ~sda_low & (sda_oe_out ? sda_out : 1'b1);

    lcd_readback #(.MEM_DEPTH(80)) i_lcd_readback (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_line),
        .address_select_pin_in(address_select_pin_in), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .address_counter_out(address_counter_out),
        .display_shift_out(display_shift_out), .data_register_out(data_register_out),
        .data_valid_out(data_valid_out));

    host_master i_host_master (.clk_in(clk_sys_in), .sda_in(sda_line), .scl_out(scl),
        .sda_low_out(sda_low));

    always #25 clk_sys_in = ~clk_sys_in;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic exp_ack);
        i_host_master.write_byte(b, ack);
        check("ack", {7'h00, exp_ack}, {7'h00, ack});
    endtask

    task automatic open_link(input logic rd_bit);
        i_host_master.bus_start();
        put({lcd_rb_pkg::SLAVE_ADDR_HI, address_select_pin_in, rd_bit}, 1'b1);
    endtask

    task automatic get(input logic give_ack, input logic [7:0] exp);
        i_host_master.read_byte(give_ack, rd);
        check("read byte", exp, rd);
    endtask

    task automatic look(input logic [7:0] cnt, input logic [7:0] dreg, input logic vld);
        check("counter", cnt, {1'b0, address_counter_out});
        check("data register", dreg, data_register_out);
        check("valid", {7'h00, vld}, {7'h00, data_valid_out});
    endtask

    // text bytes land at successive addresses
    task automatic write_text;
        open_link(1'b0);
        put(8'h40, 1'b1);
        for (int k = 0; k < 6; k++) put(TEXT[47-8*k -: 8], 1'b1);
        look(8'h06, 8'h00, 1'b0);
        i_host_master.bus_stop();
    endtask

    // set address fetches memory into the data register
    task automatic set_address;
        open_link(1'b0);
        put(8'h80, 1'b1);
        put(8'h83, 1'b1);
        look(8'h03, 8'h4E, 1'b1);
        i_host_master.bus_stop();
    endtask

    // shift right twice and left once, then return to origin; bus left open on purpose
    task automatic origin_return;
        open_link(1'b0);
        put(8'h00, 1'b1);
        put(8'h1C, 1'b1);
        put(8'h1C, 1'b1);
        check("shift", 8'h02, {1'b0, display_shift_out});
        put(8'h18, 1'b1);
        put(8'h14, 1'b1);
        check("shift", 8'h01, {1'b0, display_shift_out});
        put(8'h02, 1'b1);
        check("shift", 8'h00, {1'b0, display_shift_out});
        look(8'h00, 8'h4E, 1'b0);
    endtask

    // repeated start into a read; first byte is the stale data register
    task automatic read_back;
        open_link(1'b0);
        put(8'h40, 1'b1);
        open_link(1'b1);
        get(1'b1, 8'h4E);
        look(8'h01, 8'h49, 1'b1);
        get(1'b1, 8'h49);
        get(1'b0, 8'h47);
        look(8'h02, 8'h47, 1'b1);
        i_host_master.bus_stop();
    endtask

    // other address ignored; the selected one still answers
    task automatic other_address;
        @(posedge clk_sys_in);
        #1 address_select_pin_in = 1'b1;
        i_host_master.bus_start();
        put({lcd_rb_pkg::SLAVE_ADDR_HI, 1'b0, 1'b0}, 1'b0);
        i_host_master.bus_stop();
        open_link(1'b1);
        get(1'b0, 8'h47);
        look(8'h02, 8'h47, 1'b1);
        i_host_master.bus_stop();
        address_select_pin_in = 1'b0;
    endtask

    // last cell written, counter wraps; single data byte then control
    task automatic wrap_counter;
        open_link(1'b0);
        put(8'h80, 1'b1);
        put(8'hCF, 1'b1);
        put(8'hC0, 1'b1);
        put(8'h5A, 1'b1);
        look(8'h00, 8'h00, 1'b0);
        put(8'h80, 1'b1);
        put(8'hCF, 1'b1);
        look(8'h4F, 8'h5A, 1'b1);
        put(8'h80, 1'b1);
        put(8'h0C, 1'b1);
        look(8'h4F, 8'h5A, 1'b0);
        i_host_master.bus_stop();
    endtask

    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clk_sys_in            = 1'b0;
        reset_n_in            = 1'b0;
        address_select_pin_in = 1'b0;
        repeat (12) @(posedge clk_sys_in);
        #1 reset_n_in = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1;
        write_text();
        set_address();
        origin_return();
        read_back();
        other_address();
        wrap_counter();
        finish_test();
    end

    // about 6k cycles expected; cut off at 20k cycles
    initial begin
        #1000000;
        err_count++;
        finish_test();
    end
endmodule
